// [hw/srap_device.sv]
// device end: serial frame decoder and configuration register file
`timescale 1ns/1ns
`default_nettype none
module srap_device #(
  parameter logic [7:0]  PART_TYPE = 8'h5a,   // arbitrary value
  parameter logic [7:0]  PART_ID   = 8'h01,   // arbitrary value
  parameter logic [15:0] MAKER_ID  = 16'h1234 // arbitrary value
) (
  input  wire logic                   clk_sys_i,      // system clock
  input  wire logic                   rst_i,          // sync reset
  srap_if.dev                         link,           // serial pins
  input  wire logic [7:0]             sysref_capture_position_i,   // capture position status
  input  wire logic [7:0]             cal_status_i,   // calibration status
  output logic                        reg_wr_o,       // one-cycle write pulse
  output logic [srap_pkg::SRAP_AW-1:0] reg_addr_o,    // address of last write
  output logic [7:0]                  reg_data_o,     // byte of last write
  output logic                        frame_active_o, // chip-select held low
  output logic                        stream_o        // past first 24 bits
);
  import srap_pkg::*;

  logic              rise;
  logic              fall;
  logic [4:0]        bit_cnt;
  logic [14:0]       hdr;
  logic              rd_frame;
  logic              streaming;
  logic [SRAP_AW-1:0] addr;
  logic [SRAP_AW-1:0] next_addr;
  logic [6:0]        wr_sh;
  logic              wr_now;
  logic [7:0]        wr_byte;
  logic [5:0]        wr_idx;
  logic [5:0]        rd_idx;
  logic [7:0]        rd_byte;
  logic [7:0]        rd_sh;
  logic              stream_address_direction;
  logic              addr_hold;
  logic [7:0]        regs [SRAP_NREG];

  // finds the table slot of an address; SRAP_NREG when unlisted
  function automatic logic [5:0] reg_index(input logic [SRAP_AW-1:0] a);
    logic [5:0] idx;
    idx = 6'(SRAP_NREG);
    for (int i = 0; i < SRAP_NREG; i++) begin
      if (SRAP_ADDR[i] == a) begin
        idx = 6'(i);
      end
    end
    return idx;
  endfunction

  // live value of a read-only slot
  function automatic logic [7:0] ro_value(input int i);
    logic [7:0] v;
    v = 8'h00;
    case (i)
      SRAP_IDX_TYPE:  v = PART_TYPE;
      SRAP_IDX_PID:   v = PART_ID;
      SRAP_IDX_MK_LO: v = MAKER_ID[7:0];
      SRAP_IDX_MK_HI: v = MAKER_ID[15:8];
      SRAP_IDX_SYSR:  v = sysref_capture_position_i;
      SRAP_IDX_CALST: v = cal_status_i;
      default:        v = 8'h00;
    endcase
    return v;
  endfunction

  srap_edge u_edge (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .sclk_i    (link.sclk),
    .sel_n_i   (link.serial_chip_select_n),
    .rise_o    (rise),
    .fall_o    (fall)
  );

  // either mirrored direction bit set means ascending
  assign stream_address_direction = regs[SRAP_IDX_CFG][SRAP_DIR_HI]
                                  | regs[SRAP_IDX_CFG][SRAP_DIR_LO];
  assign addr_hold = regs[SRAP_IDX_USR][SRAP_HOLD_BIT];

  // address for the next byte of a streaming transfer
  always_comb begin
    if (addr_hold) begin
      next_addr = addr;
    end else if (stream_address_direction) begin
      next_addr = SRAP_AW'(addr + 15'h0001);
    end else begin
      next_addr = SRAP_AW'(addr - 15'h0001);
    end
  end

  // bit counter: 0..15 header, 16..23 data, then wraps to 16 per byte.
  // only serial clock edges move it, so any rate down to a stop is fine
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || link.serial_chip_select_n) begin
      bit_cnt <= 5'h00;
    end else if (rise) begin
      if (bit_cnt == SRAP_CNT_LAST) begin
        bit_cnt <= SRAP_CNT_DATA;
      end else begin
        bit_cnt <= bit_cnt + 5'h01;
      end
    end
  end

  // header shift: flag first, then address, most significant first
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      hdr      <= 15'h0000;
      rd_frame <= 1'b0;
      addr     <= 15'h0000;
    end else if (rise) begin
      if (bit_cnt < SRAP_CNT_ADDR) begin
        hdr <= {hdr[13:0], link.sdi};
      end else if (bit_cnt == SRAP_CNT_ADDR) begin
        rd_frame <= hdr[14];
        addr     <= {hdr[13:0], link.sdi};
      end else if (bit_cnt == SRAP_CNT_LAST) begin
        addr <= next_addr;
      end
    end
  end

  // streaming flag, cleared at chip-select rise
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || link.serial_chip_select_n) begin
      streaming <= 1'b0;
    end else if (rise && bit_cnt == SRAP_CNT_LAST) begin
      streaming <= 1'b1;
    end
  end

  // write data gathering; a partial byte is lost when select rises
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wr_sh <= 7'h00;
    end else if (rise && bit_cnt >= SRAP_CNT_DATA) begin
      wr_sh <= {wr_sh[5:0], link.sdi};
    end
  end

  assign wr_now  = rise && bit_cnt == SRAP_CNT_LAST && !rd_frame;
  assign wr_byte = {wr_sh, link.sdi};
  assign wr_idx  = reg_index(addr);
  assign rd_idx  = reg_index(addr);
  // unlisted addresses read as zero and swallow writes
  assign rd_byte = (rd_idx < 6'(SRAP_NREG)) ? regs[rd_idx[5:0]] : 8'h00;

  // one register per slot; read-only slots follow their sources
  for (genvar g = 0; g < SRAP_NREG; g++) begin : g_reg
    always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
        regs[g] <= SRAP_RST[g];
      end else if (SRAP_RO[g]) begin
        regs[g] <= ro_value(g);
      end else if (wr_now && wr_idx == 6'(g)) begin
        regs[g] <= wr_byte;
      end
    end
  end

  // read data leaves on falling edges so the host samples on the next rise;
  // the byte is fetched at the fall before the first data bit
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || link.serial_chip_select_n) begin
      link.sdo    <= 1'b0;
      link.sdo_oe <= 1'b0;
      rd_sh       <= 8'h00;
    end else if (fall && rd_frame && bit_cnt >= SRAP_CNT_DATA) begin
      link.sdo_oe <= 1'b1;
      if (bit_cnt == SRAP_CNT_DATA) begin
        link.sdo <= rd_byte[7];
        rd_sh    <= {rd_byte[6:0], 1'b0};
      end else begin
        link.sdo <= rd_sh[7];
        rd_sh    <= {rd_sh[6:0], 1'b0};
      end
    end
  end

  // report each stored byte to the converter logic behind the map
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      reg_wr_o   <= 1'b0;
      reg_addr_o <= 15'h0000;
      reg_data_o <= 8'h00;
    end else begin
      reg_wr_o <= wr_now && wr_idx < 6'(SRAP_NREG);
      if (wr_now) begin
        reg_addr_o <= addr;
        reg_data_o <= wr_byte;
      end
    end
  end

  // frame status for the user side
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      frame_active_o <= 1'b0;
      stream_o       <= 1'b0;
    end else begin
      frame_active_o <= ~link.serial_chip_select_n;
      stream_o       <= streaming;
    end
  end
endmodule
`default_nettype wire

// [hw/srap_pkg.sv]
// constants, register map and types of the serial register access port
package srap_pkg;
  localparam int          SRAP_AW        = 15;
  localparam int          SRAP_NREG      = 44;
  localparam logic [4:0]  SRAP_CNT_ADDR  = 5'h0f;
  localparam logic [4:0]  SRAP_CNT_DATA  = 5'h10;
  localparam logic [4:0]  SRAP_CNT_LAST  = 5'h17;
  localparam logic [5:0]  SRAP_BITS_ONE  = 6'h18;
  localparam logic [5:0]  SRAP_BITS_TWO  = 6'h20;
  // byte map; 16-bit registers take two entries, low byte first
  localparam logic [14:0] SRAP_ADDR [SRAP_NREG] = '{
    15'h000, 15'h002, 15'h003, 15'h004, 15'h00c, 15'h00d, 15'h010, 15'h029,
    15'h02a, 15'h02b, 15'h02c, 15'h030, 15'h031, 15'h032, 15'h033, 15'h038,
    15'h03b, 15'h048, 15'h04f, 15'h060, 15'h061, 15'h062, 15'h064, 15'h068,
    15'h06a, 15'h06b, 15'h06c, 15'h06e, 15'h070, 15'h071, 15'h07a, 15'h07b,
    15'h07c, 15'h07e, 15'h07f, 15'h09d, 15'h160, 15'h200, 15'h201, 15'h202,
    15'h203, 15'h204, 15'h205, 15'h206};
  localparam logic [7:0]  SRAP_RST [SRAP_NREG] = '{
    8'h30, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h11, 8'h00, 8'h00, 8'ha0, 8'h00, 8'ha0, 8'h00,
    8'h00, 8'h00, 8'h13, 8'h01, 8'h01, 8'h01, 8'h02, 8'h61,
    8'h00, 8'h00, 8'h01, 8'h88, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h1f,
    8'h01, 8'h03, 8'h00, 8'h00};
  localparam logic [SRAP_NREG-1:0] SRAP_RO = 44'h0000100043c;
  localparam int          SRAP_IDX_CFG   = 0;
  localparam int          SRAP_IDX_TYPE  = 2;
  localparam int          SRAP_IDX_PID   = 3;
  localparam int          SRAP_IDX_MK_LO = 4;
  localparam int          SRAP_IDX_MK_HI = 5;
  localparam int          SRAP_IDX_USR   = 6;
  localparam int          SRAP_IDX_SYSR  = 10;
  localparam int          SRAP_IDX_CALST = 24;
  localparam int          SRAP_DIR_HI    = 5;
  localparam int          SRAP_DIR_LO    = 2;
  localparam int          SRAP_HOLD_BIT  = 0;
  // host register indices and fields
  localparam logic [1:0]  SRAP_H_ADDR    = 2'h0;
  localparam logic [1:0]  SRAP_H_DATA    = 2'h1;
  localparam logic [1:0]  SRAP_H_CMD     = 2'h2;
  localparam int          SRAP_CMD_RD    = 0;
  localparam int          SRAP_CMD_TWO   = 1;
  localparam logic [7:0]  SRAP_HALF_CYC  = 8'h04;
  typedef enum {SRAP_HS_IDLE, SRAP_HS_LOW, SRAP_HS_HIGH, SRAP_HS_HOLD} srap_host_state_e;
endpackage

// [hw/srap_if.sv]
// four-wire link between host and device
`timescale 1ns/1ns
`default_nettype none
interface srap_if;
  logic sclk;                 // serial clock, host driven
  logic serial_chip_select_n; // frame select, active low
  logic sdi;                  // host to device data
  logic sdo;                  // device to host data
  logic sdo_oe;               // device drives sdo while high
  wire  sdo_pin;              // pin level seen by the host
  // a released pin rests at its pull-up, so a late enable reads as ones
  assign sdo_pin = sdo_oe ? sdo : 1'b1;
  modport dev (input sclk, serial_chip_select_n, sdi, output sdo, sdo_oe);
  modport host (output sclk, serial_chip_select_n, sdi, input sdo_pin);
endinterface
`default_nettype wire

// [hw/srap_edge.sv]
// serial clock edge finder gated by chip-select
`timescale 1ns/1ns
`default_nettype none
module srap_edge (
  input  wire logic clk_sys_i, // system clock
  input  wire logic rst_i,     // sync reset
  input  wire logic sclk_i,    // serial clock level
  input  wire logic sel_n_i,   // chip-select, active low
  output logic      rise_o,    // rising edge inside frame
  output logic      fall_o     // falling edge inside frame
);
  logic sclk_q;

  // pins are synchronous, so one register suffices for edges
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= sclk_i;
    end
  end

  // edges outside a frame are dropped: traffic with select high is ignored
  assign rise_o = sclk_i & ~sclk_q & ~sel_n_i;
  assign fall_o = ~sclk_i & sclk_q & ~sel_n_i;
endmodule
`default_nettype wire

// [hw/srap_host.sv]
// host end: frame generator driven from a small register port
`timescale 1ns/1ns
`default_nettype none
module srap_host #(
  parameter logic [7:0] HALF_CYC = srap_pkg::SRAP_HALF_CYC // half serial period less one, in system clocks
) (
  input  wire logic        clk_sys_i,  // system clock
  input  wire logic        rst_i,      // sync reset
  input  wire logic [1:0]  sw_addr_i,  // register index
  input  wire logic [15:0] sw_wdata_i, // write data
  input  wire logic        sw_wr_i,    // write strobe
  input  wire logic        sw_rd_i,    // read strobe
  output logic      [15:0] sw_rdata_o, // read data, cycle after strobe
  srap_if.host             link        // serial pins
);
  import srap_pkg::*;

  srap_host_state_e   state;
  logic [SRAP_AW-1:0] tgt_addr;
  logic [15:0]        tx_data;
  logic [15:0]        rx_data;
  logic               rd_op;
  logic               two_byte;
  logic               done;
  logic               start;
  logic [7:0]         timer;
  logic [31:0]        sh;
  logic [5:0]         bits_left;
  logic [15:0]        rx;

  // a command write while busy is dropped
  assign start = sw_wr_i && sw_addr_i == SRAP_H_CMD && state == SRAP_HS_IDLE;

  // software registers
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tgt_addr <= 15'h0000;
      tx_data  <= 16'h0000;
      rd_op    <= 1'b0;
      two_byte <= 1'b0;
    end else if (sw_wr_i && state == SRAP_HS_IDLE) begin
      case (sw_addr_i)
        SRAP_H_ADDR: tgt_addr <= sw_wdata_i[14:0];
        SRAP_H_DATA: tx_data  <= sw_wdata_i;
        SRAP_H_CMD: begin
          rd_op    <= sw_wdata_i[SRAP_CMD_RD];
          two_byte <= sw_wdata_i[SRAP_CMD_TWO];
        end
        default: ;
      endcase
    end
  end

  // frame engine: clock idles low, data changes on falls.
  // the caller keeps clear of calibration and only reads unlisted addresses, never writes them
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state     <= SRAP_HS_IDLE;
      link.sclk <= 1'b0;
      link.serial_chip_select_n <= 1'b1;
      link.sdi  <= 1'b0;
      timer     <= 8'h00;
      sh        <= 32'h0;
      bits_left <= 6'h00;
      rx        <= 16'h0000;
    end else begin
      case (state)
        SRAP_HS_IDLE: begin
          if (start) begin
            link.serial_chip_select_n <= 1'b0;
            // flag, address, then low byte before high byte
            sh <= {sw_wdata_i[SRAP_CMD_RD], tgt_addr, tx_data[7:0], tx_data[15:8]};
            link.sdi  <= sw_wdata_i[SRAP_CMD_RD];
            bits_left <= sw_wdata_i[SRAP_CMD_TWO] ? SRAP_BITS_TWO : SRAP_BITS_ONE;
            timer     <= HALF_CYC;
            state     <= SRAP_HS_LOW;
          end
        end
        SRAP_HS_LOW: begin
          if (timer == 8'h00) begin
            link.sclk <= 1'b1;
            rx        <= {rx[14:0], link.sdo_pin};
            bits_left <= bits_left - 6'h01;
            timer     <= HALF_CYC;
            state     <= SRAP_HS_HIGH;
          end else begin
            timer <= timer - 8'h01;
          end
        end
        SRAP_HS_HIGH: begin
          if (timer == 8'h00) begin
            link.sclk <= 1'b0;
            link.sdi  <= sh[30];
            sh        <= {sh[30:0], 1'b0};
            timer     <= HALF_CYC;
            state     <= (bits_left == 6'h00) ? SRAP_HS_HOLD : SRAP_HS_LOW;
          end else begin
            timer <= timer - 8'h01;
          end
        end
        SRAP_HS_HOLD: begin
          if (timer == 8'h00) begin
            link.serial_chip_select_n <= 1'b1;
            link.sdi <= 1'b0;
            state    <= SRAP_HS_IDLE;
          end else begin
            timer <= timer - 8'h01;
          end
        end
        default: state <= SRAP_HS_IDLE;
      endcase
    end
  end

  // result capture; first byte received is the low byte
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rx_data <= 16'h0000;
      done    <= 1'b0;
    end else if (state == SRAP_HS_HOLD && timer == 8'h00) begin
      done <= 1'b1;
      if (rd_op) begin
        rx_data <= two_byte ? {rx[7:0], rx[15:8]} : {8'h00, rx[7:0]};
      end
    end else if (start) begin
      done <= 1'b0;
    end
  end

  // read port, data one cycle after the strobe, unmapped reads zero
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sw_rdata_o <= 16'h0000;
    end else if (sw_rd_i) begin
      case (sw_addr_i)
        SRAP_H_ADDR: sw_rdata_o <= {1'b0, tgt_addr};
        SRAP_H_DATA: sw_rdata_o <= rx_data;
        SRAP_H_CMD:  sw_rdata_o <= {14'h0000, done, state != SRAP_HS_IDLE};
        default:     sw_rdata_o <= 16'h0000;
      endcase
    end else begin
      sw_rdata_o <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// [tb/srap_chk.sv]
// concurrent checks on the four serial wires
`timescale 1ns/1ns
`default_nettype none
module srap_chk (
  input wire logic clk_sys_i,            // system clock
  input wire logic rst_i,                // sync reset
  input wire logic sclk,                 // serial clock
  input wire logic serial_chip_select_n, // select, active low
  input wire logic sdi,                  // host data
  input wire logic sdo,                  // device data
  input wire logic sdo_oe                // device drives sdo
);
  logic       sclk_q;
  logic [5:0] bits;
  logic       rd;
  // last serial clock level, so rises can be counted
  always_ff @(posedge clk_sys_i) begin
    sclk_q <= sclk && !rst_i;
  end
  // rises in this frame; a deselect clears the count
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || serial_chip_select_n) begin
      bits <= 6'h00;
    end else if (sclk && !sclk_q) begin
      bits <= bits + 6'h01;
    end
  end
  // first bit taken marks a read frame
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rd <= 1'b0;
    end else if (!serial_chip_select_n && sclk && !sclk_q && bits == 6'h00) begin
      rd <= sdi;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence s_start; $fell(serial_chip_select_n); endsequence
  sequence s_end; $rose(serial_chip_select_n); endsequence
  property p_oe_idle; serial_chip_select_n [*3] |-> !sdo_oe; endproperty
  property p_oe_write; !serial_chip_select_n && !rd && bits != 6'h00 |-> !sdo_oe; endproperty
  property p_oe_addr; !serial_chip_select_n && bits < 6'h10 |-> !sdo_oe; endproperty
  property p_oe_data; !serial_chip_select_n && rd && bits > 6'h10 |-> sdo_oe; endproperty
  property p_sdo_fall; !serial_chip_select_n && $changed(sdo) |-> !sclk; endproperty
  property p_end_count; s_end |-> !sclk && bits >= 6'h18 && bits[2:0] == 3'h0; endproperty
  property p_start_gap; s_start |-> !sclk [*3]; endproperty
  property p_sdi_hold; !serial_chip_select_n && sclk && $past(sclk) |-> $stable(sdi); endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("data out driven while deselected");
  a_oe_write: assert property (p_oe_write)
    else $error("data out driven in a write frame");
  a_oe_addr: assert property (p_oe_addr)
    else $error("data out driven during flag or address");
  a_oe_data: assert property (p_oe_data)
    else $error("data out released during read data");
  a_sdo_fall: assert property (p_sdo_fall)
    else $error("data out moved while serial clock high");
  a_end_count: assert property (p_end_count)
    else $error("frame ended off a byte boundary");
  a_start_gap: assert property (p_start_gap)
    else $error("serial clock rose right after select");
  a_sdi_hold: assert property (p_sdi_hold)
    else $error("data in moved while serial clock high");
endmodule
`default_nettype wire

// [tb/srap_bench.sv]
// self-checking bench: host and device ends joined over one link
`timescale 1ns/1ns
`default_nettype none
module srap_bench;
  import srap_pkg::*;
  localparam int          LIMIT = 40000;
  localparam logic [7:0]  PTYPE = 8'h5a;    // arbitrary value
  localparam logic [15:0] MAKER = 16'h1234; // arbitrary value
  logic        clk_sys_i  = 1'b0;
  logic        rst_i      = 1'b1;
  logic [1:0]  sw_addr    = 2'h0;
  logic [15:0] sw_wdata   = 16'h0000;
  logic        sw_wr      = 1'b0;
  logic        sw_rd      = 1'b0;
  logic [15:0] sw_rdata;
  logic [7:0]  sysref_capture_position = 8'h00;
  logic [7:0]  cal_status = 8'h00;
  logic        reg_wr;
  logic        reg_wr_b;
  logic [14:0] reg_addr;
  logic [14:0] reg_addr_b;
  logic [7:0]  reg_data;
  logic [7:0]  reg_data_b;
  logic        frame_b;
  logic        stream_b;
  logic [15:0] q;
  int          errors     = 0;
  int          checked    = 0;
  int          cycles     = 0;
  int          writes     = 0;
  int          writes_b   = 0;
  srap_if u_srap_if ();
  srap_if u_srap_if_b ();
  srap_device #(.PART_TYPE(PTYPE), .MAKER_ID(MAKER)) u_srap_device (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .link(u_srap_if), .sysref_capture_position_i(sysref_capture_position), .cal_status_i(cal_status), .reg_wr_o(reg_wr),
    .reg_addr_o(reg_addr), .reg_data_o(reg_data), .frame_active_o(), .stream_o());
  // second device, bit-banged by the bench to break frames on purpose
  srap_device #(.PART_TYPE(PTYPE), .MAKER_ID(MAKER)) u_srap_device_b (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .link(u_srap_if_b), .sysref_capture_position_i(sysref_capture_position), .cal_status_i(cal_status), .reg_wr_o(reg_wr_b),
    .reg_addr_o(reg_addr_b), .reg_data_o(reg_data_b), .frame_active_o(frame_b), .stream_o(stream_b));
  srap_host u_srap_host (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sw_addr_i(sw_addr), .sw_wdata_i(sw_wdata),
    .sw_wr_i(sw_wr), .sw_rd_i(sw_rd), .sw_rdata_o(sw_rdata), .link(u_srap_if));
  srap_chk u_srap_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sclk(u_srap_if.sclk),
    .serial_chip_select_n(u_srap_if.serial_chip_select_n), .sdi(u_srap_if.sdi), .sdo(u_srap_if.sdo),
    .sdo_oe(u_srap_if.sdo_oe));
  always #10 clk_sys_i = ~clk_sys_i;
  // hang guard and device write pulse counts
  always @(posedge clk_sys_i) begin
    cycles++;
    writes += int'(reg_wr === 1'b1);
    writes_b += int'(reg_wr_b === 1'b1);
    if (cycles == LIMIT) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic done(input string s);
    $display("test %s over, errors %0d", s, errors);
  endtask
  task automatic sw_write(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk_sys_i);
    sw_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic sw_read(input logic [1:0] a, output logic [15:0] d);
    @(posedge clk_sys_i);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk_sys_i);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask
  // one serial frame through the host; status polled under a bound
  task automatic frame(input logic rd, input logic two, input logic [14:0] a, input logic [15:0] d);
    logic [15:0] st;
    int n;
    sw_write(SRAP_H_ADDR, {1'b0, a});
    sw_write(SRAP_H_DATA, d);
    sw_write(SRAP_H_CMD, {14'h0000, two, rd});
    n = 0;
    do begin
      sw_read(SRAP_H_CMD, st);
      n++;
    end while (st[0] !== 1'b0 && n < 200);
    chk({14'h0000, st[1:0]}, 16'h0002, "status"); // frame closed
    sw_read(SRAP_H_DATA, q);
  endtask
  task automatic rd_chk(input logic two, input logic [14:0] a, input logic [15:0] exp);
    frame(1'b1, two, a, 16'h0000);
    chk(two ? q : {8'h00, q[7:0]}, exp, "read");
  endtask
  task automatic t_reset();
    logic [14:0] a [7] = '{15'h000, 15'h003, 15'h00c, 15'h00d, 15'h02b, 15'h04f, 15'h202};
    logic [7:0]  v [7] = '{8'h30, PTYPE, MAKER[7:0], MAKER[15:8], 8'h11, 8'h13, 8'h1f};
    for (int i = 0; i < 7; i++) begin
      rd_chk(1'b0, a[i], {8'h00, v[i]}); // reset map
    end
    rd_chk(1'b1, 15'h030, 16'ha000); // low byte first
    done("reset");
  endtask
  task automatic t_write();
    int n;
    n = writes;
    frame(1'b0, 1'b0, 15'h029, 16'h00a5);
    chk(16'(writes - n), 16'h0001, "pulses"); // one store
    chk({1'b0, reg_addr}, 16'h0029, "addr"); // address field
    chk({8'h00, reg_data}, 16'h00a5, "data"); // last eight bits
    rd_chk(1'b0, 15'h029, 16'h00a5); // read back
    sw_read(SRAP_H_ADDR, q);
    chk(q, 16'h0029, "target"); // target kept
    frame(1'b0, 1'b0, 15'h003, 16'h00ff);
    rd_chk(1'b0, 15'h003, {8'h00, PTYPE}); // read-only kept
    n = writes;
    // a read with its data bits set: they must be ignored
    frame(1'b1, 1'b0, 15'h029, 16'h0077);
    chk({8'h00, q[7:0]}, 16'h00a5, "read");
    chk(16'(writes - n), 16'h0000, "pulses"); // no store on read
    rd_chk(1'b0, 15'h001, 16'h0000); // reserved address only read
    @(posedge clk_sys_i);
    sysref_capture_position <= 8'h3c;
    cal_status <= 8'hc3; // a status value only, no calibration runs
    rd_chk(1'b0, 15'h02c, 16'h003c); // live status
    rd_chk(1'b0, 15'h06a, 16'h00c3); // live status
    done("write");
  endtask
  // each direction setting, then a two-byte write at 0x061
  task automatic t_dir();
    logic [7:0] cfg [4] = '{8'h00, 8'h20, 8'h04, 8'h24};
    for (int i = 0; i < 4; i++) begin
      frame(1'b0, 1'b0, 15'h000, {8'h00, cfg[i]});
      frame(1'b0, 1'b1, 15'h061, {8'h90 + 8'(i), 8'h50 + 8'(i)});
      rd_chk(1'b0, 15'h061, {8'h00, 8'h50 + 8'(i)}); // first byte
      rd_chk(1'b0, (i == 0) ? 15'h060 : 15'h062, {8'h00, 8'h90 + 8'(i)}); // step
    end
    frame(1'b0, 1'b0, 15'h000, 16'h0030);
    done("direction");
  endtask
  task automatic t_hold();
    frame(1'b0, 1'b0, 15'h010, 16'h0001);
    frame(1'b0, 1'b1, 15'h048, 16'h9966);
    rd_chk(1'b0, 15'h048, 16'h0099); // address held
    rd_chk(1'b1, 15'h048, 16'h9999); // address held
    frame(1'b0, 1'b0, 15'h010, 16'h0000);
    rd_chk(1'b0, 15'h010, 16'h0000); // hold cleared
    done("hold");
  endtask
  // bench drives the second link; the clock stands still between frames
  task automatic bb(input logic [23:0] v, input int n, input int half);
    @(posedge clk_sys_i);
    u_srap_if_b.serial_chip_select_n <= 1'b0;
    for (int i = 23; i > 23 - n; i--) begin
      repeat (half) @(posedge clk_sys_i);
      u_srap_if_b.sdi <= v[i];
      repeat (half) @(posedge clk_sys_i);
      u_srap_if_b.sclk <= 1'b1;
      repeat (half) @(posedge clk_sys_i);
      u_srap_if_b.sclk <= 1'b0;
    end
    repeat (half) @(posedge clk_sys_i);
    chk({14'h0000, frame_b, stream_b}, {14'h0000, 1'b1, n >= 24}, "frame flags");
    u_srap_if_b.serial_chip_select_n <= 1'b1;
    u_srap_if_b.sdi <= ~u_srap_if_b.sdi;
    repeat (half) @(posedge clk_sys_i);
    chk({14'h0000, frame_b, stream_b}, 16'h0000, "frame flags");
  endtask
  task automatic t_abort();
    bb({1'b0, 15'h02a, 8'h00}, 11, 2); // cut frame
    bb({1'b0, 15'h029, 8'h3c}, 24, 40); // slow clock
    chk(16'(writes_b), 16'h0001, "pulses"); // partial dropped
    chk({1'b0, reg_addr_b}, 16'h0029, "addr"); // counter restarted
    chk({8'h00, reg_data_b}, 16'h003c, "data"); // slow clock kept
    done("abort");
  endtask
  initial begin
    u_srap_if_b.sclk = 1'b0;
    u_srap_if_b.serial_chip_select_n = 1'b1;
    u_srap_if_b.sdi = 1'b0;
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_reset();
    t_write();
    t_dir();
    t_hold();
    t_abort();
    tally_and_finish();
  end
endmodule
`default_nettype wire
